// >>> vic_top.v
// Vectored interrupt controller: flags, enables, priority, vector hand-off.
// Assumes a core that honours take_out/vector_out, pulses vec_ack_in when
// it jumps, and reports stack-full, sleep and phase-two pulses.
//
// Contract
// - Source events set their request flag.
// - Master enable low blocks all servicing.
// - Per-source enable bits gate servicing.
// - Accept pushes PC then loads vector.
// - Return pops saved PC back.
// - Service entry clears master enable.
// - Flags still latch while master disabled.
// - Stack full blocks acknowledge; flag stays.
// - Normal jump after two or three cycles.
// - Wake jump three cycles after wake.
// - Requests sampled at next phase-two pulse.
// - Four-source priority and vectors 04H-10H.
// - Five-source priority and vectors 04H-14H.
// - External request always wins ties.
// - External needs master, pin enable, edge.
// - Edge-select bits 6/7 choose trigger.
// - Servicing external clears its flag.
// - Flag stays set while disabled.
// - Master enable bit 0, resets zero.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.vh"

module vic_top
#(
  parameter FIVE_SRC = 1  // 1: five sources, 0: four sources.
)
(
  input  wire       sys_clk_in,          // System clock, 250 MHz.
  input  wire       reset_n_in,          // Synchronous reset, active low.
  input  wire [2:0] reg_addr_in,         // Register index.
  input  wire [7:0] reg_wdata_in,        // Write data.
  input  wire       reg_wr_in,           // Write strobe.
  input  wire       reg_rd_in,           // Read strobe.
  output reg  [7:0] reg_rdata_out,       // Read data, one cycle after strobe.
  input  wire       port_a_line_three_in,   // External request pin.
  input  wire       timer0_ovf_in,       // Timer 0 overflow pulse.
  input  wire       timer1_ovf_in,       // Timer 1 overflow pulse.
  input  wire       conv_done_in,        // Conversion complete pulse.
  input  wire       time_base_in,        // Time base event pulse.
  input  wire       phase_two_pulse_in,  // Core phase-two pulse.
  input  wire       instr_cycle_in,      // One pulse per instruction cycle.
  input  wire       stack_full_in,       // Core return stack is full.
  input  wire       sleep_in,            // Core is in sleep or idle.
  input  wire       reti_in,             // Core executes return-from-interrupt.
  input  wire       vec_ack_in,          // Core accepts the vector.
  output reg        take_out,            // Request to push PC and jump.
  output reg  [7:0] vector_out,          // Vector address.
  output reg        push_pc_out,         // Push PC pulse on acceptance.
  output reg        pop_pc_out,          // Pop PC pulse on return.
  output reg        wake_out             // Wake request to the core.
);

  // Active source count; vectors are spaced four words apart.
  localparam [2:0] NSRC = FIVE_SRC ? 3'h5 : 3'h4;

  // Dispatch states.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_TAKE = 2'h2;

  reg        master_irq_enable;     // Global enable.
  reg  [4:0] src_enable;            // Per-source enables, priority order.
  reg  [4:0] src_flag;              // Per-source request flags.
  reg  [1:0] edge_sel;              // Edge-select {high, low}.
  reg  [5:0] misc_spare;            // Remaining bits of misc register one.
  reg  [4:0] sampled;               // Requests latched at phase two.
  reg  [1:0] state;                 // Dispatch state.
  reg  [1:0] lat_cnt;               // Instruction cycles left before jump.
  reg  [2:0] win_idx;               // Winner held across the wait.
  reg        wake_pend;             // Dispatch started from sleep.
  wire       pin_edge;              // Qualified pin edge pulse.
  wire [4:0] src_event;             // Events in priority order.
  wire [4:0] live_mask;             // Sources present in this variant.
  wire [4:0] gated;                 // Sampled requests passing all gates.
  wire [2:0] pick;                  // Priority winner index.
  wire       pick_any;              // Some request wins.
  wire       accept;                // Core takes the vector this cycle.
  reg  [7:0] next_rdata;            // Read mux value.
  reg  [4:0] clr_mask;              // Flags cleared by hardware this cycle.

  // Priority order: pin, timer 0, timer 1 (five-source only), conversion, time base.
  assign src_event = FIVE_SRC ?
    {time_base_in, conv_done_in, timer1_ovf_in, timer0_ovf_in, pin_edge} :
    {1'b0, time_base_in, conv_done_in, timer0_ovf_in, pin_edge};
  assign live_mask = FIVE_SRC ? 5'h1f : 5'h0f;

  // Master, per-source enable and stack state gate what the picker sees.
  assign gated = (master_irq_enable && !stack_full_in) ?
                 (sampled & src_flag & src_enable & live_mask) : 5'h00;
  assign accept = (state == ST_TAKE) && vec_ack_in;

  vic_pin_sync u_pin
  (
    .sys_clk_in   (sys_clk_in),
    .reset_n_in   (reset_n_in),
    .pin_in       (port_a_line_three_in),
    .edge_sel_in  (edge_sel),
    .edge_hit_out (pin_edge)
  );

  vic_prio u_prio
  (
    .req_in     (gated),
    .winner_out (pick),
    .any_out    (pick_any)
  );

  // Hardware clear of the winner on acceptance.
  always @*
  begin
    clr_mask = 5'h00;
    if (accept)
    begin
      clr_mask[win_idx] = 1'b1;
    end
  end

  // Register file writes and flag maintenance; event sets win over any clear.
  always @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      master_irq_enable <= 1'b0;
      src_enable        <= 5'h00;
      src_flag          <= 5'h00;
      edge_sel          <= `VIC_EDGE_OFF;
      misc_spare        <= 6'h00;
    end
    else
    begin
      src_flag <= (src_flag & ~clr_mask) | (src_event & live_mask);
      if (reg_wr_in)
      begin
        case (reg_addr_in)
          `VIC_ADDR_CTRL_A:
          begin
            master_irq_enable <= reg_wdata_in[`VIC_BIT_MASTER_EN];
            src_enable[1:0]   <= reg_wdata_in[2:1];
            // Software may clear or set flags; a same-cycle event still sets.
            src_flag[1:0] <= (reg_wdata_in[5:4] & ~clr_mask[1:0]) | src_event[1:0];
            if (FIVE_SRC)
            begin
              src_enable[2] <= reg_wdata_in[3];
              src_flag[2]   <= (reg_wdata_in[6] & ~clr_mask[2]) | src_event[2];
            end
            else
            begin
              src_enable[2] <= reg_wdata_in[3];
              src_flag[2]   <= (reg_wdata_in[6] & ~clr_mask[2]) | src_event[2];
            end
          end
          `VIC_ADDR_CTRL_B:
          begin
            src_enable[4:3] <= reg_wdata_in[1:0] & live_mask[4:3];
            src_flag[4:3]   <= ((reg_wdata_in[5:4] & ~clr_mask[4:3]) | src_event[4:3])
                               & live_mask[4:3];
          end
          `VIC_ADDR_MISC_ONE:
          begin
            edge_sel   <= {reg_wdata_in[`VIC_BIT_EDGE_HIGH],
                           reg_wdata_in[`VIC_BIT_EDGE_LOW]};
            misc_spare <= reg_wdata_in[5:0];
          end
          default:
          begin
            edge_sel <= edge_sel;
          end
        endcase
      end
      if (accept)
      begin
        master_irq_enable <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped indices read zero.
  always @*
  begin
    next_rdata = `VIC_RESET_BYTE;
    case (reg_addr_in)
      `VIC_ADDR_CTRL_A:
        next_rdata = {1'b0, src_flag[2:0], src_enable[2:0], master_irq_enable};
      `VIC_ADDR_CTRL_B:
        next_rdata = {2'b00, src_flag[4:3], 2'b00, src_enable[4:3]};
      `VIC_ADDR_MISC_ONE:
        next_rdata = {edge_sel[1], edge_sel[0], misc_spare};
      `VIC_ADDR_STATUS:
        next_rdata = {state, take_out, wake_pend, 1'b0, win_idx};
      default:
        next_rdata = `VIC_RESET_BYTE;
    endcase
  end

  // Sampling, latency count and vector hand-off.
  always @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      reg_rdata_out <= `VIC_RESET_BYTE;
      sampled       <= 5'h00;
      state         <= ST_IDLE;
      lat_cnt       <= 2'h0;
      win_idx       <= 3'h0;
      wake_pend     <= 1'b0;
      take_out      <= 1'b0;
      vector_out    <= `VIC_VEC_BASE;
      push_pc_out   <= 1'b0;
      pop_pc_out    <= 1'b0;
      wake_out      <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= reg_rd_in ? next_rdata : `VIC_RESET_BYTE;
      pop_pc_out    <= reti_in;
      push_pc_out   <= accept;
      // Pending enabled flags wake a sleeping core regardless of master enable.
      wake_out <= sleep_in && |(src_flag & src_enable & live_mask);
      if (phase_two_pulse_in)
      begin
        sampled <= src_flag;
      end
      case (state)
        ST_IDLE:
        begin
          if (pick_any && phase_two_pulse_in)
          begin
            win_idx   <= pick;
            wake_pend <= sleep_in;
            lat_cnt   <= sleep_in ? `VIC_LAT_WAKE : `VIC_LAT_NORMAL;
            state     <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // Sleep holds the count; it starts after wake-up.
          if (instr_cycle_in && !sleep_in)
          begin
            if (lat_cnt == 2'h1)
            begin
              if (stack_full_in || !master_irq_enable)
              begin
                state <= ST_IDLE;
              end
              else
              begin
                take_out   <= 1'b1;
                vector_out <= `VIC_VEC_BASE + {3'h0, win_idx, 2'b00};
                state      <= ST_TAKE;
              end
            end
            lat_cnt <= lat_cnt - 2'h1;
          end
        end
        ST_TAKE:
        begin
          if (vec_ack_in)
          begin
            take_out  <= 1'b0;
            wake_pend <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> vic_defines.vh
// Constants for the vectored interrupt controller: register offsets,
// bit positions, reset values, vectors and timing counts.
// Assumes inclusion by bare name from the design files of this block.
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// Register indices on the plain register port (3-bit address).
`define VIC_ADDR_CTRL_A        3'h0
`define VIC_ADDR_CTRL_B        3'h1
`define VIC_ADDR_MISC_ONE      3'h2
`define VIC_ADDR_STATUS        3'h3

// Control register A: master enable, pin enable and pin flag.
`define VIC_BIT_MASTER_EN      0
`define VIC_BIT_PIN_EN         1
`define VIC_BIT_PIN_FLAG       4
// Misc control register one: edge-select bits.
`define VIC_BIT_EDGE_LOW       6
`define VIC_BIT_EDGE_HIGH      7

// Edge-select encodings.
`define VIC_EDGE_OFF           2'b00
`define VIC_EDGE_RISE          2'b01
`define VIC_EDGE_FALL          2'b10
`define VIC_EDGE_BOTH          2'b11

// Source indices in fixed priority order, lowest index wins.
`define VIC_SRC_PIN            0
`define VIC_SRC_MAX            5

// Vector table: base vector and spacing of four program words.
`define VIC_VEC_BASE           8'h04
`define VIC_VEC_STEP           8'h04

// Latency from sampling to vector jump, in instruction cycles.
`define VIC_LAT_NORMAL         2'h2
`define VIC_LAT_WAKE           2'h3

`define VIC_RESET_BYTE         8'h00

`endif

// >>> vic_pin_sync.v
// Pin synchroniser and edge qualifier for the external request line.
// Assumes the pin is asynchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.vh"

module vic_pin_sync
(
  input  wire       sys_clk_in,      // System clock.
  input  wire       reset_n_in,      // Synchronous reset, active low.
  input  wire       pin_in,          // Raw asynchronous pin level.
  input  wire [1:0] edge_sel_in,     // Edge-select code.
  output reg        edge_hit_out     // One-cycle pulse on a qualifying edge.
);

  reg       sync_a;   // First stage, read only by sync_b.
  reg       sync_b;   // Second stage.
  reg       sync_c;   // Third stage.
  reg       level;    // Filtered level, changes once stages two and three agree.
  wire      agree;    // Stages two and three hold the same value.
  wire      rise;     // Filtered level goes high.
  wire      fall;     // Filtered level goes low.

  assign agree = (sync_b == sync_c);
  assign rise  = agree && sync_c && !level;
  assign fall  = agree && !sync_c && level;

  // Three-stage synchroniser and edge decode; edges are qualified by the select code.
  always @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      sync_a       <= 1'b0;
      sync_b       <= 1'b0;
      sync_c       <= 1'b0;
      level        <= 1'b0;
      edge_hit_out <= 1'b0;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (agree)
      begin
        level <= sync_c;
      end
      // Code 00 disables the pin entirely.
      case (edge_sel_in)
        `VIC_EDGE_RISE: edge_hit_out <= rise;
        `VIC_EDGE_FALL: edge_hit_out <= fall;
        `VIC_EDGE_BOTH: edge_hit_out <= rise | fall;
        default:        edge_hit_out <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> vic_prio.v
// Fixed-priority picker: lowest-numbered requesting source wins.
// Assumes requests are already gated by enables.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.vh"

module vic_prio
(
  input  wire [4:0] req_in,      // Gated requests, bit 0 highest priority.
  output reg  [2:0] winner_out,  // Index of winning source.
  output reg        any_out      // At least one request.
);

  integer i;  // Scan index.

  // Scan from highest to lowest so the last hit, the lowest index, wins.
  always @*
  begin
    winner_out = 3'h0;
    any_out    = 1'b0;
    for (i = `VIC_SRC_MAX - 1; i >= 0; i = i - 1)
    begin
      if (req_in[i])
      begin
        winner_out = i[2:0];
        any_out    = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> vic_top_sva.sv
// Checker for vic_top: vector hand-off, stack, wake and read port.
// Assumes the bind below and one clock with a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module vic_top_sva
#(
  parameter FIVE_SRC = 1
)
(
  input wire logic       sys_clk_in,
  input wire logic       reset_n_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       stack_full_in,
  input wire logic       sleep_in,
  input wire logic       reti_in,
  input wire logic       vec_ack_in,
  input wire logic       take_out,
  input wire logic [7:0] vector_out,
  input wire logic       push_pc_out,
  input wire logic       pop_pc_out,
  input wire logic       wake_out
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Top of the vector table; the four-source build stops one slot earlier.
  wire [7:0] last_vec = (FIVE_SRC != 0) ? 8'h14 : 8'h10;

  property p_take_hold; take_out && !vec_ack_in |=> take_out && $stable(vector_out); endproperty
  a_take_hold: assert property (p_take_hold) else $error("vector request not held");
  property p_take_end; take_out && vec_ack_in |=> !take_out && push_pc_out; endproperty
  a_take_end: assert property (p_take_end) else $error("accept did not push");
  property p_push_src; push_pc_out |-> $past(take_out && vec_ack_in); endproperty
  a_push_src: assert property (p_push_src) else $error("push without accept");
  property p_pop; reti_in |=> pop_pc_out; endproperty
  a_pop: assert property (p_pop) else $error("return did not pop");
  property p_pop_src; pop_pc_out |-> $past(reti_in); endproperty
  a_pop_src: assert property (p_pop_src) else $error("pop without return");
  property p_vec;
    take_out |-> vector_out[1:0] == 2'b00 && vector_out >= 8'h04 && vector_out <= last_vec;
  endproperty
  a_vec: assert property (p_vec) else $error("vector outside table");
  property p_full; $rose(take_out) |-> !$past(stack_full_in); endproperty
  a_full: assert property (p_full) else $error("request taken with stack full");
  property p_wake; wake_out |-> $past(sleep_in); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_rdata; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule

bind vic_top vic_top_sva #(.FIVE_SRC(FIVE_SRC)) u_vic_sva (.sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .stack_full_in(stack_full_in), .sleep_in(sleep_in), .reti_in(reti_in),
  .vec_ack_in(vec_ack_in), .take_out(take_out), .vector_out(vector_out),
  .push_pc_out(push_pc_out), .pop_pc_out(pop_pc_out), .wake_out(wake_out));
`default_nettype wire

// >>> vic_core_model.sv
// Model of the core sequencer: instruction timing, vector acceptance
// and return stack depth. Assumes the same clock and reset as vic_top.
`timescale 1ns/1ps
`default_nettype none
module vic_core_model
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       take_in,      // Controller asks for a jump.
  input  wire logic       push_in,      // Return address pushed.
  input  wire logic       pop_in,       // Return address popped.
  input  wire logic [1:0] ack_dly_in,   // Stall cycles before accepting.
  input  wire logic [3:0] stack_lim_in, // Stack levels available.
  output wire logic       phase_two_out,
  output wire logic       instr_out,
  output var  logic       ack_out,
  output wire logic       full_out
);
  logic [1:0] phase_cnt; // Four clocks make one instruction cycle.
  logic [1:0] wait_cnt;  // Stall cycles spent on the current vector.
  logic [3:0] depth;     // Return addresses held on the stack.
  // Sampling and cycle pulses sit in different slots so they never coincide.
  assign phase_two_out = (phase_cnt == 2'h1);
  assign instr_out = (phase_cnt == 2'h3);
  assign full_out = (depth >= stack_lim_in);
  // Accept a vector after the chosen stall, which may be none.
  always @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      phase_cnt <= 2'h0;
      wait_cnt <= 2'h0;
      depth <= 4'h0;
      ack_out <= 1'b0;
    end
    else
    begin
      phase_cnt <= phase_cnt + 2'h1;
      depth <= depth + {3'h0, push_in} - {3'h0, pop_in};
      ack_out <= 1'b0;
      if (take_in && !ack_out && wait_cnt == ack_dly_in)
      begin
        ack_out <= 1'b1;
        wait_cnt <= 2'h0;
      end
      else if (take_in && !ack_out)
        wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for vic_top with expected register images.
// Assumes vic_core_model supplies pulses, acceptance and stack-full.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b0;
  logic       t0 = 1'b0, t1 = 1'b0, cv = 1'b0, tbv = 1'b0, sleep = 1'b0, reti = 1'b0;
  logic       phase, instr, ack, full, take, push, pop, wake;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, vec, ra, rb, d;
  logic [1:0] ack_dly = 2'h0;
  logic [3:0] lim = 4'h8;
  int         num_errors = 0, compares = 0, n, k;

  vic_top #(.FIVE_SRC(1)) dut (.sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .port_a_line_three_in(pin), .timer0_ovf_in(t0), .timer1_ovf_in(t1), .conv_done_in(cv),
    .time_base_in(tbv), .phase_two_pulse_in(phase), .instr_cycle_in(instr),
    .stack_full_in(full), .sleep_in(sleep), .reti_in(reti), .vec_ack_in(ack),
    .take_out(take), .vector_out(vec), .push_pc_out(push), .pop_pc_out(pop), .wake_out(wake));
  vic_core_model u_core (.sys_clk_in(clk), .reset_n_in(rst_n), .take_in(take), .push_in(push),
    .pop_in(pop), .ack_dly_in(ack_dly), .stack_lim_in(lim), .phase_two_out(phase),
    .instr_out(instr), .ack_out(ack), .full_out(full));

  // Clock of 4 ns.
  always #2 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write; a gap cycle follows so strobes never collide.
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] x,
                        input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata & m, x & m, what);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {tbv, cv, t1, t0} <= m;
    @(posedge clk);
    {tbv, cv, t1, t0} <= 4'h0;
  endtask
  task automatic ret(input int cnt);
    @(posedge clk);
    reti <= 1'b1;
    repeat (cnt) @(posedge clk);
    reti <= 1'b0;
  endtask
  // Waits for a jump request, counting instruction pulses on the way.
  task automatic wait_take(input logic [7:0] x, input int lo, input int hi);
    int i;
    n = 0;
    for (i = 0; i < 300 && take !== 1'b1; i++)
    begin
      @(posedge clk);
      #1 n = n + int'(instr);
    end
    check({7'h0, take}, 8'h01, "take");
    check(vec, x, "vector");
    check({7'h0, n >= lo && n <= hi}, 8'h01, "latency");
  endtask
  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end

  initial
  begin
    void'($urandom(37));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 4; k++)
      rd_chk(k[2:0], 8'hff, 8'h00, "reset value");
    wr_reg(3'h5, 8'h5a);
    rd_chk(3'h5, 8'hff, 8'h00, "unmapped");
    d = 8'($urandom);
    wr_reg(3'h2, d);
    rd_chk(3'h2, 8'hc0, d, "edge bits");
    // Every edge code, pin enabled but master off: flags latch, no jump.
    ra = 8'h02;
    wr_reg(3'h0, ra);
    for (k = 0; k < 4; k++)
    begin
      wr_reg(3'h2, {k[1:0], 6'h00});
      pin <= 1'b1;
      repeat (8) @(posedge clk);
      rd_chk(3'h0, 8'hff, ra | {3'h0, k[0], 4'h0}, "rise flag");
      wr_reg(3'h0, ra);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
      rd_chk(3'h0, 8'hff, ra | {3'h0, k[1], 4'h0}, "fall flag");
      wr_reg(3'h0, ra);
    end
    check({7'h0, take}, 8'h00, "masked take");
    // All five sources at once, then serviced one by one with nesting.
    wr_reg(3'h2, 8'h40);
    ra = 8'h0e;
    rb = 8'h03;
    wr_reg(3'h0, ra);
    wr_reg(3'h1, rb);
    pin <= 1'b1;
    pulse(4'hf);
    repeat (8) @(posedge clk);
    ra = 8'h7e;
    rb = 8'h33;
    rd_chk(3'h0, 8'hff, ra, "flags a");
    rd_chk(3'h1, 8'hff, rb, "flags b");
    for (k = 0; k < 5; k++)
    begin
      ack_dly <= 2'($urandom);
      wr_reg(3'h0, ra | 8'h01);
      wait_take(8'h04 + 8'h04 * k[7:0], 2, 4);
      repeat (6) @(posedge clk);
      if (k < 3)
        ra = ra & ~(8'h10 << k);
      else
        rb = rb & ~(8'h10 << (k - 3));
      rd_chk(3'h0, 8'hff, ra, "after accept a");
      rd_chk(3'h1, 8'hff, rb, "after accept b");
    end
    // Stack full: request waits with its flag until one return.
    lim <= 4'h5;
    pulse(4'h1);
    ra = 8'h2f;
    wr_reg(3'h0, ra);
    repeat (40) @(posedge clk);
    check({7'h0, take}, 8'h00, "stack full take");
    rd_chk(3'h0, 8'hff, ra, "held by stack");
    ret(1);
    wait_take(8'h08, 1, 4);
    ret(5);
    // Disabled source keeps its flag until software clears it.
    rb = 8'h01;
    wr_reg(3'h1, rb);
    ra = 8'h0f;
    wr_reg(3'h0, ra);
    pulse(4'h8);
    repeat (40) @(posedge clk);
    check({7'h0, take}, 8'h00, "disabled take");
    rd_chk(3'h1, 8'hff, 8'h21, "held flag");
    wr_reg(3'h1, rb);
    rd_chk(3'h1, 8'hff, rb, "cleared flag");
    // Request during sleep wakes the core; the bench plays the core waking up.
    sleep <= 1'b1;
    pulse(4'h4);
    for (k = 0; k < 50 && wake !== 1'b1; k++)
      @(posedge clk);
    check({7'h0, wake}, 8'h01, "wake");
    // Let the dispatch start while asleep, then count from the wake-up edge.
    repeat (8) @(posedge clk);
    @(posedge clk);
    sleep <= 1'b0;
    #1 k = int'(instr);
    wait_take(8'h10, 3 - k, 4 - k);
    repeat (6) @(posedge clk);
    ret(1);
    rd_chk(3'h0, 8'hff, 8'h0e, "after wake a");
    rd_chk(3'h1, 8'hff, rb, "after wake b");
    summarize();
  end
endmodule
`default_nettype wire
